/* File: hdl/arseq_pkg.sv */
`default_nettype none
package arseq_pkg;
    // Time base
    localparam int CLK_HZ       = 25_000_000;
    localparam int TICK_MS      = 1;
    localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
    localparam int TW           = 16;
    localparam logic [TW-1:0] T_INFINITE = 16'hffff;
    // Sequencing limits
    localparam int MAX_CYCLES   = 8;
    localparam int PARAM_SETS   = 4;
    localparam int NUM_SRC      = 8;
    localparam logic [3:0] MAX_CYC_W = 4'h8;
    localparam logic [3:0] LAST_SET  = 4'h4;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_RECLAIM   = 8'h04;
    localparam logic [7:0] OFS_BLOCK_MC  = 8'h08;
    localparam logic [7:0] OFS_READY_MON = 8'h0c;
    localparam logic [7:0] OFS_DEAD_EXT  = 8'h10;
    localparam logic [7:0] OFS_OPEN_MON  = 8'h14;
    localparam logic [7:0] OFS_REMOTE    = 8'h18;
    localparam logic [7:0] OFS_DEAD_3P   = 8'h1c;
    localparam logic [7:0] OFS_DEAD0     = 8'h20;
    localparam logic [7:0] OFS_STATUS    = 8'h30;
    localparam logic [7:0] OFS_STEP      = 8'h04;
    // Control fields
    localparam int CB_ON        = 0;
    localparam int CB_PRESENT   = 1;
    localparam int CB_RDY_CHK   = 2;
    localparam int CB_ADT       = 3;
    localparam int CB_EV_TRIP   = 4;
    localparam int CB_EV_3P     = 5;
    localparam int CB_F3P       = 6;
    localparam int CB_PAUX      = 7;
    localparam int CB_REM_ADT   = 8;
    localparam int CF_CYC_LO    = 12;
    localparam int CF_SRC_LO    = 16;
    // Reset values
    localparam logic [31:0]   CTRL_RST      = 32'h00ff_1002;
    localparam logic [TW-1:0] RECLAIM_RST   = 16'h0bb8;
    localparam logic [TW-1:0] BLOCK_MC_RST  = 16'h0000;
    localparam logic [TW-1:0] READY_MON_RST = 16'h0bb8;
    localparam logic [TW-1:0] OPEN_MON_RST  = 16'h01f4;
    localparam logic [TW-1:0] REMOTE_RST    = 16'h0000;
    localparam logic [TW-1:0] DEAD_RST      = 16'h01f4;
    // Synchronised input vector layout
    localparam int IN_PICKUP = 0;
    localparam int IN_1POLE  = 1;
    localparam int IN_READY  = 2;
    localparam int IN_OPEN   = 3;
    localparam int IN_MC     = 4;
    localparam int IN_BLOCK  = 5;
    localparam int IN_EXT    = 6;
    localparam int IN_POLE   = 7;
    localparam int IN_TRIP   = 10;
    localparam int IN_W      = 18;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DEAD    = 3'b001,
        ST_CLOSE   = 3'b011,
        ST_RECLAIM = 3'b010,
        ST_BLOCKED = 3'b110
    } arseq_state_t;
endpackage
`default_nettype wire

/* File: hdl/arseq_top.sv */
// How it works
// - Function removed: no reclose outputs, inputs ignored, every fault trips three-pole.
// - At most eight reclose attempts per fault sequence, never more.
// - Cycles one to four own dead times; later cycles reuse the fourth.
// - Master on/off switch; when off no reclose command appears.
// - Optional check: breaker ready must be high at the first trip.
// - Ready monitor runs in dead time; expiry without readiness blocks.
// - Dead time extension waiting for readiness is capped unless set infinite.
// - Reclaim time resets sequencer; re-trip inside starts next cycle or fails.
// - Adaptive mode with zero reclaim time skips reclaim entirely.
// - Fault inside manual-close block time: no reclose, final three-pole trip.
// - Pickup criterion: any pickup during dead time is an evolving fault.
// - Trip criterion: only trips, external ones too, mark evolving faults.
// - Adaptive mode ignores evolving fault settings.
// - Reaction stop: evolving fault ends the sequence without reclose.
// - Reaction start-3p: evolving fault starts separate three-pole dead time.
// - Open monitor from each trip; breaker not open in time blocks.
// - Remote close sent after a delay, only when far end is adaptive.
// - Eight trip sources each enabled to start reclosure or not.
// - Phase aux contacts plus forced mode: two poles open forces three-pole.
// - Forced mode: block during single-pole dead time trips three poles.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module arseq_top #(
    parameter int TICK_CYCLES = arseq_pkg::TICK_CYC
) (
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_b_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [7:0]                  paddr_in,
    input  wire logic [31:0]                 pwdata_in,
    output logic      [31:0]                 prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    input  wire logic [arseq_pkg::NUM_SRC-1:0] src_trip_in,
    input  wire logic                        pickup_in,
    input  wire logic                        single_pole_trip_in,
    input  wire logic                        breaker_ready_input_in,
    input  wire logic                        breaker_open_in,
    input  wire logic [2:0]                  pole_open_in,
    input  wire logic                        manual_close_in,
    input  wire logic                        block_in,
    input  wire logic                        ext_trip_in,
    output logic                             close_out,
    output logic                             remote_close_out,
    output logic                             block_out,
    output logic                             trip3p_out
);
    import arseq_pkg::*;

    typedef struct packed {
        arseq_state_t                 st;
        logic [IN_W-1:0]              s1;
        logic [IN_W-1:0]              s2;
        logic [IN_W-1:0]              s3;
        logic [IN_W-1:0]              f;
        logic [IN_W-1:0]              fp;
        logic [15:0]                  tick_cnt;
        logic                         tick;
        logic [31:0]                  ctrl;
        logic [TW-1:0]                t_reclaim;
        logic [TW-1:0]                manual_close_block_time;
        logic [TW-1:0]                t_ready_mon;
        logic [TW-1:0]                dead_time_extension_limit;
        logic [TW-1:0]                t_open_mon;
        logic [TW-1:0]                t_remote;
        logic [TW-1:0]                t_dead3p;
        logic [PARAM_SETS-1:0][TW-1:0] t_dead;
        logic [TW-1:0]                dead_tmr;
        logic [TW-1:0]                mon_tmr;
        logic [TW-1:0]                open_tmr;
        logic [TW-1:0]                ext_tmr;
        logic [TW-1:0]                rcl_tmr;
        logic [TW-1:0]                mc_tmr;
        logic [TW-1:0]                rem_tmr;
        logic                         rem_run;
        logic                         open_run;
        logic                         evolved;
        logic                         one_pole;
        logic [3:0]                   cycle;
        logic [3:0]                   closes;
        logic                         close;
        logic                         remote_close;
        logic                         blk;
        logic                         trip3p_hold;
        logic                         trip3p;
        logic [31:0]                  prdata;
        logic                         pslverr;
    } arseq_regs_t;

    arseq_regs_t r;
    arseq_regs_t n;

    function automatic logic [TW-1:0] tdec(input logic [TW-1:0] t,
                                           input logic          tk);
        return (tk && t != '0) ? t - TW'(1'b1) : t;
    endfunction

    function automatic logic [1:0] set_idx(input logic [3:0] c);
        return (c >= LAST_SET) ? 2'(PARAM_SETS - 1) : 2'(c - 4'h1);
    endfunction

    logic [IN_W-1:0] raw;
    logic            present;
    logic            on_sw;
    logic            adaptive_dead_time_mode;
    logic            f3p;
    logic [3:0]      maxc;
    logic            any_trip;
    logic            start_lvl;
    logic            start_edge;
    logic            evolving;
    logic            two_poles;
    logic            go_block;
    logic            enter_dead;
    logic [3:0]      nc;
    logic            apb_acc;
    logic            mapped;

    assign raw = {src_trip_in, pole_open_in, ext_trip_in, block_in,
                  manual_close_in, breaker_open_in, breaker_ready_input_in,
                  single_pole_trip_in, pickup_in};
    assign pready_out       = 1'b1;
    assign prdata_out       = r.prdata;
    assign pslverr_out      = r.pslverr;
    assign close_out        = r.close;
    assign remote_close_out = r.remote_close;
    assign block_out        = r.blk;
    assign trip3p_out       = r.trip3p;

    always_comb begin
        n = r;
        n.close        = 1'b0;
        n.remote_close = 1'b0;
        n.blk          = 1'b0;
        go_block       = 1'b0;
        enter_dead     = 1'b0;
        nc             = r.cycle;

        // Three-stage input synchroniser with agreement filter
        n.s1 = raw;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.f  = (r.s2 & r.s3) | (r.f & (r.s2 ^ r.s3));
        n.fp = r.f;

        // Millisecond tick
        n.tick = 1'b0;
        if (r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            n.tick_cnt = '0;
            n.tick     = 1'b1;
        end else begin
            n.tick_cnt = r.tick_cnt + 16'h0001;
        end

        // APB slave, zero wait states
        apb_acc = psel_in && penable_in;
        mapped  = 1'b1;
        n.prdata  = '0;
        unique case (paddr_in)
            OFS_CTRL:      n.prdata = r.ctrl;
            OFS_RECLAIM:   n.prdata = {16'h0000, r.t_reclaim};
            OFS_BLOCK_MC:  n.prdata = {16'h0000, r.manual_close_block_time};
            OFS_READY_MON: n.prdata = {16'h0000, r.t_ready_mon};
            OFS_DEAD_EXT:  n.prdata = {16'h0000, r.dead_time_extension_limit};
            OFS_OPEN_MON:  n.prdata = {16'h0000, r.t_open_mon};
            OFS_REMOTE:    n.prdata = {16'h0000, r.t_remote};
            OFS_DEAD_3P:   n.prdata = {16'h0000, r.t_dead3p};
            OFS_STATUS:    n.prdata = {16'h0000, r.closes, r.cycle,
                                       r.trip3p, r.evolved, r.one_pole,
                                       r.open_run, 1'b0, r.st};
            default: begin
                mapped = 1'b0;
                for (int i = 0; i < PARAM_SETS; i++) begin
                    if (paddr_in == OFS_DEAD0 + 8'(i) * OFS_STEP) begin
                        mapped   = 1'b1;
                        n.prdata = {16'h0000, r.t_dead[i]};
                    end
                end
            end
        endcase
        if (!(psel_in && !penable_in)) begin
            n.prdata = r.prdata;
        end
        n.pslverr = psel_in && !mapped;
        if (apb_acc && pwrite_in && mapped) begin
            unique case (paddr_in)
                OFS_CTRL:      n.ctrl        = pwdata_in;
                OFS_RECLAIM:   n.t_reclaim   = pwdata_in[TW-1:0];
                OFS_BLOCK_MC:  n.manual_close_block_time  = pwdata_in[TW-1:0];
                OFS_READY_MON: n.t_ready_mon = pwdata_in[TW-1:0];
                OFS_DEAD_EXT:  n.dead_time_extension_limit  = pwdata_in[TW-1:0];
                OFS_OPEN_MON:  n.t_open_mon  = pwdata_in[TW-1:0];
                OFS_REMOTE:    n.t_remote    = pwdata_in[TW-1:0];
                OFS_DEAD_3P:   n.t_dead3p    = pwdata_in[TW-1:0];
                default: begin
                    for (int i = 0; i < PARAM_SETS; i++) begin
                        if (paddr_in == OFS_DEAD0 + 8'(i) * OFS_STEP) begin
                            n.t_dead[i] = pwdata_in[TW-1:0];
                        end
                    end
                end
            endcase
        end

        // Settings and decoded events
        present = r.ctrl[CB_PRESENT];
        on_sw   = r.ctrl[CB_ON];
        adaptive_dead_time_mode     = r.ctrl[CB_ADT];
        f3p     = r.ctrl[CB_F3P];
        maxc = (r.ctrl[CF_CYC_LO+:4] > MAX_CYC_W) ? MAX_CYC_W
                                                  : r.ctrl[CF_CYC_LO+:4];
        any_trip = (|r.f[IN_TRIP+:NUM_SRC]) || r.f[IN_EXT];
        start_lvl  = |(r.f[IN_TRIP+:NUM_SRC] & r.ctrl[CF_SRC_LO+:NUM_SRC]);
        start_edge = |(r.f[IN_TRIP+:NUM_SRC] & ~r.fp[IN_TRIP+:NUM_SRC]
                       & r.ctrl[CF_SRC_LO+:NUM_SRC]);
        evolving = !adaptive_dead_time_mode && (r.ctrl[CB_EV_TRIP]
            ? ((|(r.f[IN_TRIP+:NUM_SRC] & ~r.fp[IN_TRIP+:NUM_SRC]))
               || (r.f[IN_EXT] && !r.fp[IN_EXT]))
            : (r.f[IN_PICKUP] && !r.fp[IN_PICKUP]));
        two_poles = (r.f[IN_POLE] && r.f[IN_POLE+1])
                 || (r.f[IN_POLE] && r.f[IN_POLE+2])
                 || (r.f[IN_POLE+1] && r.f[IN_POLE+2]);

        // Timers
        n.rcl_tmr  = tdec(r.rcl_tmr, r.tick);
        n.rem_tmr  = tdec(r.rem_tmr, r.tick);
        n.open_tmr = tdec(r.open_tmr, r.tick);
        n.mc_tmr   = tdec(r.mc_tmr, r.tick);
        if (r.f[IN_MC] && !r.fp[IN_MC]) begin
            n.mc_tmr = r.manual_close_block_time;
        end

        if (r.open_run) begin
            if (r.f[IN_OPEN] || !any_trip) begin
                n.open_run = 1'b0;
            end else if (r.open_tmr == '0) begin
                go_block = 1'b1;
            end
        end

        if (r.rem_run && r.rem_tmr == '0) begin
            n.rem_run      = 1'b0;
            n.remote_close = 1'b1;
        end

        unique case (r.st)
            ST_IDLE: begin
                n.cycle  = '0;
                n.closes = '0;
                if (start_lvl && !r.f[IN_BLOCK] && maxc != '0) begin
                    if (r.mc_tmr != '0) begin
                        go_block      = 1'b1;
                        n.trip3p_hold = 1'b1;
                    end else if (r.ctrl[CB_RDY_CHK] && !r.f[IN_READY]) begin
                        // breaker not ready at first trip
                        go_block = 1'b1;
                    end else begin
                        enter_dead = 1'b1;
                        nc         = 4'h1;
                    end
                end
            end
            ST_DEAD: begin
                n.dead_tmr = tdec(r.dead_tmr, r.tick);
                if (r.f[IN_READY]) begin
                    n.mon_tmr = r.t_ready_mon;
                end else begin
                    n.mon_tmr = tdec(r.mon_tmr, r.tick);
                    if (r.mon_tmr == '0) begin
                        go_block = 1'b1;
                    end
                end
                if (r.f[IN_BLOCK]) begin
                    go_block = 1'b1;
                end
                if (evolving && !r.evolved) begin
                    if (!r.ctrl[CB_EV_3P]) begin
                        go_block = 1'b1;
                    end else begin
                        n.evolved  = 1'b1;
                        n.one_pole = 1'b0;
                        n.dead_tmr = r.t_dead3p;
                        n.open_run = 1'b1;
                        n.open_tmr = r.t_open_mon;
                    end
                end else if (r.dead_tmr == '0) begin
                    if (r.f[IN_READY]) begin
                        n.st = ST_CLOSE;
                    end else begin
                        n.ext_tmr = tdec(r.ext_tmr, r.tick);
                        if (r.dead_time_extension_limit != T_INFINITE && r.ext_tmr == '0) begin
                            go_block = 1'b1;
                        end
                    end
                end
            end
            ST_CLOSE: begin
                n.close  = 1'b1;
                n.closes = r.closes + 4'h1;
                if (r.ctrl[CB_REM_ADT]) begin
                    n.rem_run = 1'b1;
                    n.rem_tmr = r.t_remote;
                end
                if (adaptive_dead_time_mode && r.t_reclaim == '0) begin
                    n.st = ST_IDLE;
                end else begin
                    n.st      = ST_RECLAIM;
                    n.rcl_tmr = r.t_reclaim;
                end
            end
            ST_RECLAIM: begin
                if (start_edge) begin
                    if (r.cycle < maxc) begin
                        enter_dead = 1'b1;
                        nc         = r.cycle + 4'h1;
                    end else begin
                        go_block      = 1'b1;
                        n.trip3p_hold = 1'b1;
                    end
                end else if (r.f[IN_BLOCK]) begin
                    go_block = 1'b1;
                end else if (r.rcl_tmr == '0) begin
                    n.st = ST_IDLE;
                end
            end
            ST_BLOCKED: begin
                if (!any_trip && !r.f[IN_PICKUP]) begin
                    n.st          = ST_IDLE;
                    n.trip3p_hold = 1'b0;
                end
            end
        endcase

        if (enter_dead && !go_block) begin
            n.st       = ST_DEAD;
            n.cycle    = nc;
            n.dead_tmr = r.t_dead[set_idx(nc)];
            n.mon_tmr  = r.t_ready_mon;
            n.ext_tmr  = r.dead_time_extension_limit;
            n.open_run = 1'b1;
            n.open_tmr = r.t_open_mon;
            n.evolved  = 1'b0;
            n.one_pole = r.f[IN_1POLE];
        end

        if (go_block && r.st != ST_BLOCKED) begin
            n.st       = ST_BLOCKED;
            n.blk      = 1'b1;
            n.rem_run  = 1'b0;
            n.open_run = 1'b0;
            if (f3p && r.one_pole && r.st == ST_DEAD) begin
                n.trip3p_hold = 1'b1;
            end
        end

        if (!on_sw) begin
            n.st           = ST_IDLE;
            n.close        = 1'b0;
            n.remote_close = 1'b0;
            n.rem_run      = 1'b0;
            n.open_run     = 1'b0;
            n.blk          = 1'b0;
            n.trip3p_hold  = 1'b0;
        end
        // forced coupling on two open poles
        n.trip3p = n.trip3p_hold || (f3p && r.ctrl[CB_PAUX] && two_poles);
        if (!present) begin
            n.st           = ST_IDLE;
            n.close        = 1'b0;
            n.remote_close = 1'b0;
            n.rem_run      = 1'b0;
            n.open_run     = 1'b0;
            n.blk          = 1'b0;
            n.trip3p_hold  = 1'b0;
            n.trip3p       = any_trip;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r             <= '0;
            r.st          <= ST_IDLE;
            r.ctrl        <= CTRL_RST;
            r.t_reclaim   <= RECLAIM_RST;
            r.manual_close_block_time  <= BLOCK_MC_RST;
            r.t_ready_mon <= READY_MON_RST;
            r.dead_time_extension_limit  <= T_INFINITE;
            r.t_open_mon  <= OPEN_MON_RST;
            r.t_remote    <= REMOTE_RST;
            r.t_dead3p    <= DEAD_RST;
            r.t_dead      <= {PARAM_SETS{DEAD_RST}};
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    AST_REMOVED: assert property (
        !r.ctrl[CB_PRESENT] |=> !close_out && !remote_close_out && !block_out)
        else $error("Reclose output while function removed");
    AST_MAX_ATTEMPTS: assert property (
        close_out |-> r.closes <= MAX_CYC_W && r.closes != '0)
        else $error("Reclose beyond attempt limit");
    AST_MASTER_OFF: assert property (
        !r.ctrl[CB_ON] |=> !close_out ##1 !close_out)
        else $error("Reclose while switched off");
    AST_FIRST_READY: assert property (
        (r.st == ST_IDLE && start_lvl && r.ctrl[CB_RDY_CHK]
         && !r.f[IN_READY] && r.ctrl[CB_ON] && present)
        |=> r.st != ST_DEAD)
        else $error("Sequence started with breaker not ready");
    AST_READY_MON: assert property (
        (r.st == ST_DEAD && !r.f[IN_READY] && r.mon_tmr == '0
         && on_sw && present) |=> block_out && r.st == ST_BLOCKED)
        else $error("Ready monitor expiry did not block");
    AST_MC_BLOCK: assert property (
        (r.st == ST_IDLE && start_lvl && r.mc_tmr != '0 && maxc != '0
         && !r.f[IN_BLOCK] && on_sw && present)
        |=> trip3p_out && r.st == ST_BLOCKED)
        else $error("Manual close window did not force final trip");
    AST_EV_STOP: assert property (
        (r.st == ST_DEAD && evolving && !r.evolved && !r.ctrl[CB_EV_3P]
         && on_sw && present) |=> r.st == ST_BLOCKED ##1 !close_out)
        else $error("Evolving fault did not stop sequence");
    AST_OPEN_MON: assert property (
        (r.open_run && r.open_tmr == '0 && !r.f[IN_OPEN] && any_trip
         && r.st != ST_BLOCKED && on_sw && present) |=> block_out)
        else $error("Open monitor expiry did not block");
    AST_ADT_RECLAIM: assert property (
        (r.st == ST_CLOSE && adaptive_dead_time_mode && r.t_reclaim == '0 && on_sw && present)
        |=> close_out && r.st == ST_IDLE)
        else $error("Zero reclaim in adaptive mode not skipped");
endmodule
`default_nettype wire

/* File: sim/arseq_brk_model.sv */
`timescale 1ns/100ps
`default_nettype none
module arseq_brk_model (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       trip_in,
    input  wire logic       close_in,
    output logic            open_out,
    output logic [2:0]      pole_open_out
);
    // Breaker opens on any trip, closes on command
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            open_out <= 1'b0;
        end else if (trip_in) begin
            open_out <= 1'b1;
        end else if (close_in) begin
            open_out <= 1'b0;
        end
    end
    assign pole_open_out = {3{open_out}};
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import arseq_pkg::*;
    logic        clk, rst_b, psel, pen, pwr, blk, rdy, perr;
    logic        pready, pslverr, cls, opn;
    logic        pick, sp, mc, ext, bo, rc, t3;
    logic [7:0]  paddr, src;
    logic [2:0]  poles;
    logic [31:0] pwdata, prdata, q;
    int          errors, total_checks, closes, blocks, rems;
    arseq_top #(.TICK_CYCLES(4)) i_dut (
        .ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .src_trip_in(src), .pickup_in(pick),
        .single_pole_trip_in(sp), .breaker_ready_input_in(rdy),
        .breaker_open_in(opn), .pole_open_in(poles),
        .manual_close_in(mc), .block_in(blk), .ext_trip_in(ext),
        .close_out(cls), .remote_close_out(rc), .block_out(bo),
        .trip3p_out(t3));
    arseq_brk_model i_brk (.clk_in(clk), .rst_b_in(rst_b),
        .trip_in(|src), .close_in(cls), .open_out(opn),
        .pole_open_out(poles));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cls === 1'b1) closes <= closes + 1;
        if (bo === 1'b1) blocks <= blocks + 1;
        if (rc === 1'b1) rems <= rems + 1;
    end
    task automatic check(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Trip one source, then count reclose pulses
    task automatic fault(input int s, input logic b, r, input int e);
        int c0;
        c0 = closes;
        @(posedge clk);
        blk <= b;
        rdy <= r;
        src[s] <= 1'b1;
        repeat (20) @(posedge clk);
        src <= 8'h00;
        rdy <= 1'b1;
        repeat (300) @(posedge clk);
        blk <= 1'b0;
        check("closes", 32'(closes - c0), 32'(e));
    endtask
    // Re-trip inside reclaim with one cycle allowed
    task automatic retrip;
        int c0, b0, r0;
        c0 = closes;
        b0 = blocks;
        r0 = rems;
        apb(1, OFS_CTRL, 32'h00fb_1107);
        @(posedge clk);
        src[0] <= 1'b1;
        repeat (8) @(posedge clk);
        src[0] <= 1'b0;
        repeat (10) @(posedge clk);
        src[0] <= 1'b1;
        repeat (10) @(posedge clk);
        check("final_trip", 32'(t3), 32'h1);
        src[0] <= 1'b0;
        repeat (20) @(posedge clk);
        check("trip_clear", 32'(t3), 32'h0);
        check("rt_closes", 32'(closes - c0), 32'h1);
        check("rt_blocks", 32'(blocks - b0), 32'h1);
        check("remote", 32'(rems - r0), 32'h1);
    endtask
    // Trip inside the manual-close window
    task automatic mclose;
        int c0;
        c0 = closes;
        apb(1, OFS_BLOCK_MC, 32'h5);
        @(posedge clk);
        mc <= 1'b1;
        repeat (4) @(posedge clk);
        src[0] <= 1'b1;
        repeat (10) @(posedge clk);
        check("mc_trip", 32'(t3), 32'h1);
        src[0] <= 1'b0;
        mc <= 1'b0;
        repeat (10) @(posedge clk);
        apb(1, OFS_BLOCK_MC, 32'h0);
        check("mc_closes", 32'(closes - c0), 32'h0);
    endtask
    // Pickup during single-pole dead time stops the sequence
    task automatic evolve;
        int c0, b0;
        c0 = closes;
        b0 = blocks;
        apb(1, OFS_DEAD0, 32'ha);
        apb(1, OFS_CTRL, 32'h00fb_1047);
        @(posedge clk);
        sp <= 1'b1;
        src[0] <= 1'b1;
        repeat (12) @(posedge clk);
        pick <= 1'b1;
        repeat (8) @(posedge clk);
        check("ev_trip3p", 32'(t3), 32'h1);
        {pick, sp, src} <= '0;
        repeat (60) @(posedge clk);
        check("ev_closes", 32'(closes - c0), 32'h0);
        check("ev_blocks", 32'(blocks - b0), 32'h1);
    endtask
    // Function removed: every trip three-pole, no reclose
    task automatic removed;
        int c0;
        c0 = closes;
        apb(1, OFS_CTRL, 32'h00fb_1005);
        @(posedge clk);
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        check("rm_trip3p", 32'(t3), 32'h1);
        ext <= 1'b0;
        src[0] <= 1'b1;
        repeat (20) @(posedge clk);
        src[0] <= 1'b0;
        repeat (8) @(posedge clk);
        check("rm_idle", 32'(t3), 32'h0);
        check("rm_closes", 32'(closes - c0), 32'h0);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge clk);
        errors++;
        give_verdict;
    end
    initial begin
        {psel, pen, pwr, blk, src, paddr, pwdata} = '0;
        {pick, sp, mc, ext} = '0;
        rdy = 1'b1;
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, OFS_CTRL, 0);
        check("ctrl", q, CTRL_RST);
        apb(0, 8'h3c, 0);
        check("slverr", 32'(perr), 32'h1);
        fault(2, 0, 1, 0);
        apb(1, OFS_DEAD0, 32'h2);
        apb(1, OFS_RECLAIM, 32'h5);
        apb(1, OFS_CTRL, CTRL_RST | 32'h1);
        fault(2, 0, 0, 1);
        fault(2, 1, 1, 0);
        apb(1, OFS_CTRL, 32'h00fb_1007);
        fault(2, 0, 1, 0);
        fault(0, 0, 0, 0);
        fault(0, 0, 1, 1);
        retrip;
        mclose;
        evolve;
        removed;
        give_verdict;
    end
endmodule
`default_nettype wire
